// [verilog/fsd_pkg.sv]
// Package: shared constants and types for the store decoder
`default_nettype none
package fsd_pkg;
  // ------------------------------------------------------------
  // Instruction field positions (two halfwords, first in [31:16])
  // ------------------------------------------------------------
  localparam int unsigned FSD_P_BIT = 24;
  localparam int unsigned FSD_U_BIT = 23;
  localparam int unsigned FSD_D_BIT = 22;
  localparam int unsigned FSD_W_BIT = 21;
  localparam int unsigned FSD_RN_LSB = 16;
  localparam int unsigned FSD_VD_LSB = 12;
  localparam int unsigned FSD_SZ_BIT = 8;
  localparam int unsigned FSD_OFS_LSB = 0;
  // ------------------------------------------------------------
  // Opcode match
  // ------------------------------------------------------------
  localparam logic [31:0] FSD_OP_MASK = 32'hFE100E00;
  localparam logic [31:0] FSD_OP_MATCH = 32'hEC000A00;
  localparam logic [3:0] FSD_PC_INDEX = 4'hF;
  localparam logic [31:0] FSD_WORD_BYTES = 32'h00000004;
  localparam logic [5:0] FSD_MAX_DREGS = 6'h10;
  localparam int unsigned FSD_REG_BITS = 5;

  typedef enum logic [1:0] {
    FSD_FLT_NONE,
    FSD_FLT_UNDEF,
    FSD_FLT_UNPRED,
    FSD_FLT_MEM
  } fsd_fault_t;
endpackage
`default_nettype wire

// [verilog/fsd_store_if.sv]
// Interface: word store request channel between the sequencer and the word buffer
`timescale 1ns/1ps
`default_nettype none
interface fsd_store_if;
  logic valid;
  logic ready;
  logic [31:0] addr;
  logic [31:0] data;
  logic last;
  modport src (output valid, output addr, output data, output last, input ready);
  modport dst (input valid, input addr, input data, input last, output ready);
endinterface
`default_nettype wire

// [verilog/fsd_word_reg.sv]
// Word register stage that holds one store word toward the memory system
`timescale 1ns/1ps
`default_nettype none
module fsd_word_reg
  import fsd_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  fsd_store_if.dst in_if,
  input wire logic mem_ready_i,
  output logic mem_valid_o,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_data_o,
  output logic mem_last_o
);
  logic full_reg;

  // Take a word only when empty or when the held one leaves
  assign in_if.ready = !full_reg || mem_ready_i;
  assign mem_valid_o = full_reg;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      full_reg <= 1'b0;
    end
    else if (in_if.valid && in_if.ready)
    begin
      full_reg <= 1'b1;
    end
    else if (mem_ready_i)
    begin
      full_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mem_addr_o <= 32'h00000000;
      mem_data_o <= 32'h00000000;
      mem_last_o <= 1'b0;
    end
    else if (in_if.valid && in_if.ready)
    begin
      mem_addr_o <= in_if.addr;
      mem_data_o <= in_if.data;
      mem_last_o <= in_if.last;
    end
  end
endmodule
`default_nettype wire

// [verilog/fsd_store_decode.sv]
// Floating-point store decoder: single and multiple register stores to word writes
// ------------------------------------------------------------
// What this block does
// - Single store address is base plus or minus the offset field times four.
// - Double single store uses the extension bit above the register field, two words.
// - Single-precision store uses the extension bit below the register field, one word.
// - A single store based on the program counter is flagged unpredictable and writes nothing.
// - A double store writes two words at A and A+4, low half first unless big-endian.
// - A single-precision store writes exactly one aligned word at the address.
// - Offsets 0 to 1020 in steps of four are supported, zero acting as plus zero.
// - Multiple store with pre clear and up set writes ascending from the base.
// - Multiple store with pre set and up clear ends just below the base, writeback forced.
// - Writeback set updates the base with the final address; clear leaves it.
// - First register comes from extension bit and register field; count is halved for doubles.
// - Undefined and memory faults are reported and no later store word completes.
// - A multiple store with pre equal to up and writeback set is undefined.
// ------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module fsd_store_decode
  import fsd_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic instr_valid_i,
  output logic instr_ready_o,
  input wire logic [31:0] instr_i,
  input wire logic [31:0] base_value_i,
  input wire logic big_endian_i,
  output logic [3:0] fp_rd_index_o,
  input wire logic [31:0] fp_rd_data_i,
  input wire logic mem_ready_i,
  input wire logic mem_fault_i,
  output logic mem_valid_o,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_data_o,
  output logic mem_last_o,
  output logic wb_valid_o,
  output logic [3:0] wb_index_o,
  output logic [31:0] wb_value_o,
  output logic done_o,
  output fsd_pkg::fsd_fault_t fault_o
);
  import fsd_pkg::*;

  // ------------------------------------------------------------
  // Field decode
  // ------------------------------------------------------------
  logic f_p, f_u, f_d, f_w, f_dbl, f_match, is_single, is_multi;
  logic [3:0] f_rn, fp_reg_field;
  logic [7:0] offset_count_field;
  logic [31:0] ofs32, single_addr;
  logic [5:0] first_reg, reg_count;
  logic undef_c, unpred_c;

  assign f_p = instr_i[FSD_P_BIT];
  assign f_u = instr_i[FSD_U_BIT];
  assign f_d = instr_i[FSD_D_BIT];
  assign f_w = instr_i[FSD_W_BIT];
  assign f_dbl = instr_i[FSD_SZ_BIT];
  assign f_rn = instr_i[FSD_RN_LSB +: 4];
  assign fp_reg_field = instr_i[FSD_VD_LSB +: 4];
  assign offset_count_field = instr_i[FSD_OFS_LSB +: 8];
  assign f_match = (instr_i & FSD_OP_MASK) == FSD_OP_MATCH;
  // Single store is pre set with writeback clear
  assign is_single = f_match && f_p && !f_w;
  assign is_multi = f_match && !is_single && (f_p || f_u || f_w);
  assign ofs32 = {22'h000000, offset_count_field, 2'h0};
  assign single_addr = f_u ? base_value_i + ofs32 : base_value_i - ofs32;
  // Doubles count in registers of two words, singles in one
  assign first_reg = f_dbl ? {1'b0, f_d, fp_reg_field}
                           : {1'b0, fp_reg_field, f_d};
  assign reg_count = f_dbl ? {1'b0, offset_count_field[5:1]}
                           : offset_count_field[5:0];
  assign undef_c = is_multi && (f_p == f_u) && f_w;
  // Zero counts, count fields above 63 and double counts above 16 are flagged unpredictable and nothing is stored; other count limits belong to software
  assign unpred_c = (f_rn == FSD_PC_INDEX)
                    || (is_multi && (reg_count == 6'h00
                    || offset_count_field[7:6] != 2'h0
                    || (f_dbl && reg_count > FSD_MAX_DREGS)));

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  typedef enum logic [1:0] {FSD_IDLE, FSD_READ, FSD_ISSUE, FSD_DRAIN} fsd_state_t;
  fsd_state_t state_reg;
  logic [31:0] addr_reg, end_addr_reg;
  logic [5:0] words_left_reg;
  logic [4:0] reg_idx_reg;
  logic dbl_reg, hi_half_reg, wb_reg, be_reg;
  logic [3:0] rn_reg;
  logic issue_fire, abort;

  fsd_store_if st_if ();

  assign instr_ready_o = state_reg == FSD_IDLE;
  assign abort = mem_fault_i && state_reg != FSD_IDLE;

  // Double d is singles 2d (low) and 2d+1 (high); big-endian sends the high one first
  // while the addresses still climb, so only the read index flips
  always_comb
  begin
    fp_rd_index_o = reg_idx_reg[3:0];
    if (dbl_reg)
    begin
      fp_rd_index_o[0] = hi_half_reg ^ be_reg;
    end
  end

  assign st_if.valid = state_reg == FSD_ISSUE && !mem_fault_i;
  assign st_if.addr = addr_reg;
  assign st_if.data = fp_rd_data_i;
  assign st_if.last = words_left_reg == 6'h01;
  assign issue_fire = st_if.valid && st_if.ready;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= FSD_IDLE;
      addr_reg <= 32'h00000000;
      end_addr_reg <= 32'h00000000;
      words_left_reg <= 6'h00;
      reg_idx_reg <= 5'h00;
      dbl_reg <= 1'b0;
      hi_half_reg <= 1'b0;
      wb_reg <= 1'b0;
      be_reg <= 1'b0;
      rn_reg <= 4'h0;
    end
    else if (abort)
    begin
      state_reg <= FSD_IDLE;
    end
    else
    begin
      case (state_reg)
        FSD_IDLE:
        begin
          // Pre, up and writeback all clear is another instruction and is left alone
          if (instr_valid_i && (is_single || is_multi) && !undef_c && !unpred_c)
          begin
            state_reg <= FSD_READ;
            dbl_reg <= f_dbl;
            be_reg <= big_endian_i;
            rn_reg <= f_rn;
            hi_half_reg <= 1'b0;
            reg_idx_reg <= f_dbl ? {first_reg[3:0], 1'b0} : first_reg[4:0];
            if (is_single)
            begin
              addr_reg <= single_addr;
              words_left_reg <= f_dbl ? 6'h02 : 6'h01;
              wb_reg <= 1'b0;
            end
            else
            begin
              words_left_reg <= f_dbl ? {reg_count[4:0], 1'b0} : reg_count;
              // Decrement-before starts one block below base
              addr_reg <= f_u ? base_value_i : base_value_i - ofs32;
              end_addr_reg <= f_u ? base_value_i + ofs32 : base_value_i - ofs32;
              wb_reg <= f_w;
            end
          end
        end
        FSD_READ:
        begin
          state_reg <= FSD_ISSUE;
        end
        FSD_ISSUE:
        begin
          if (issue_fire)
          begin
            addr_reg <= addr_reg + FSD_WORD_BYTES;
            words_left_reg <= words_left_reg - 6'h01;
            reg_idx_reg <= reg_idx_reg + 5'h01;
            if (dbl_reg)
            begin
              hi_half_reg <= !hi_half_reg;
            end
            state_reg <= st_if.last ? FSD_DRAIN : FSD_READ;
          end
        end
        FSD_DRAIN:
        begin
          if (!mem_valid_o)
          begin
            state_reg <= FSD_IDLE;
          end
        end
        default:
        begin
          state_reg <= FSD_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Results
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      done_o <= 1'b0;
      fault_o <= FSD_FLT_NONE;
      wb_valid_o <= 1'b0;
      wb_index_o <= 4'h0;
      wb_value_o <= 32'h00000000;
    end
    else
    begin
      done_o <= 1'b0;
      wb_valid_o <= 1'b0;
      if (abort)
      begin
        done_o <= 1'b1;
        fault_o <= FSD_FLT_MEM;
      end
      else if (state_reg == FSD_IDLE && instr_valid_i && (is_single || is_multi)
               && (undef_c || unpred_c))
      begin
        done_o <= 1'b1;
        fault_o <= undef_c ? FSD_FLT_UNDEF : FSD_FLT_UNPRED;
      end
      else if (state_reg == FSD_DRAIN && !mem_valid_o)
      begin
        done_o <= 1'b1;
        fault_o <= FSD_FLT_NONE;
        wb_valid_o <= wb_reg;
        wb_index_o <= rn_reg;
        wb_value_o <= end_addr_reg;
      end
    end
  end

  fsd_word_reg u_word (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .in_if(st_if),
    .mem_ready_i(mem_ready_i),
    .mem_valid_o(mem_valid_o),
    .mem_addr_o(mem_addr_o),
    .mem_data_o(mem_data_o),
    .mem_last_o(mem_last_o)
  );
endmodule
`default_nettype wire

// [tb/fsd_store_decode_props.sv]
// Checker: port-level properties of the store decoder
`timescale 1ns/1ps
`default_nettype none
module fsd_store_decode_props
  import fsd_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic instr_valid_i,
  input wire logic instr_ready_o,
  input wire logic [31:0] instr_i,
  input wire logic mem_ready_i,
  input wire logic mem_fault_i,
  input wire logic mem_valid_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic mem_last_o,
  input wire logic wb_valid_o,
  input wire logic done_o,
  input wire logic [1:0] fault_o
);
  import fsd_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic take;
  logic seq_reg;
  logic w_reg;
  logic [31:0] acc_reg;
  assign take = instr_valid_i && instr_ready_o && (instr_i & FSD_OP_MASK) == FSD_OP_MATCH;
  // Last accepted word, so the next one can be tied to it
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      seq_reg <= 1'b0;
      acc_reg <= '0;
    end
    else if (mem_valid_o && mem_ready_i)
    begin
      seq_reg <= !mem_last_o;
      acc_reg <= mem_addr_o;
    end
    else if (done_o)
      seq_reg <= 1'b0;
  end
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      w_reg <= 1'b0;
    else if (take)
      w_reg <= instr_i[FSD_W_BIT];
  end
  a_word_hold:
    assert property (mem_valid_o && !mem_ready_i && !mem_fault_i |=> mem_valid_o
      && $stable(mem_addr_o)) else $error("stalled word changed");
  a_word_align:
    assert property (mem_valid_o |-> mem_addr_o[1:0] == 2'h0) else $error("unaligned word");
  a_addr_step:
    assert property (mem_valid_o && seq_reg |-> mem_addr_o == acc_reg + FSD_WORD_BYTES)
    else $error("word address not consecutive");
  a_undef_reject:
    assert property (take && instr_i[FSD_P_BIT] == instr_i[FSD_U_BIT] && instr_i[FSD_W_BIT]
      |-> ##[1:2] (done_o && fault_o == FSD_FLT_UNDEF && !mem_valid_o))
    else $error("undefined form not rejected");
  a_pc_base:
    assert property (take && instr_i[FSD_RN_LSB +: 4] == FSD_PC_INDEX && instr_i[FSD_P_BIT]
      && !instr_i[FSD_W_BIT] |-> ##[1:2] (done_o && fault_o == FSD_FLT_UNPRED && !mem_valid_o))
    else $error("pc base not flagged");
  a_wb_gate:
    assert property (wb_valid_o |-> w_reg) else $error("writeback without request");
  a_last_done:
    assert property (mem_valid_o && mem_ready_i && mem_last_o && !mem_fault_i
      |-> ##[1:4] (done_o && fault_o == FSD_FLT_NONE)) else $error("no finish after last");
  a_fault_end:
    assert property (mem_fault_i && !instr_ready_o |-> ##[1:40] (done_o
      && fault_o == FSD_FLT_MEM)) else $error("memory fault not reported");
endmodule
bind fsd_store_decode fsd_store_decode_props u_props (.*);
`default_nettype wire

// [tb/fsd_mem_model.sv]
// Partner model: memory system taking word store requests
`timescale 1ns/1ps
`default_nettype none
module fsd_mem_model (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic mem_valid_i,
  input wire logic slow_i,
  input wire logic [3:0] fault_at_i,
  output logic mem_ready_o,
  output logic mem_fault_o
);
  logic ph_reg;
  logic [3:0] cnt_reg;
  // Slow mode takes every other cycle to force stalls
  assign mem_ready_o = !slow_i || ph_reg;
  assign mem_fault_o = mem_valid_i && fault_at_i != 4'h0 && cnt_reg == fault_at_i - 4'h1;
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      ph_reg <= 1'b0;
    else
      ph_reg <= !ph_reg;
  end
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      cnt_reg <= 4'h0;
    else if (fault_at_i == 4'h0)
      cnt_reg <= 4'h0;
    else if (mem_valid_i && mem_ready_o)
      cnt_reg <= cnt_reg + 4'h1;
  end
endmodule
`default_nettype wire

// [tb/fsd_store_decode_test.sv]
// Testbench: directed store scenarios for the store decoder
`timescale 1ns/1ps
`default_nettype none
module fsd_store_decode_test;
  import fsd_pkg::*;
  logic clk_sys_i, rst_i, instr_valid_i, mem_ready_i, mem_fault_i, slow, wbf, be;
  logic instr_ready_o, mem_valid_o, mem_last_o, wb_valid_o, done_o;
  logic [31:0] instr_i, base_value_i, fp_rd_data_i, mem_addr_o, mem_data_o, wb_value_o, wbv;
  logic [3:0] fp_rd_index_o, wb_index_o, fault_at, wbi;
  fsd_fault_t fault_o;
  logic [31:0] wq[$];
  logic [31:0] dq[$];
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  // Register file stand-in: value names its own index
  assign fp_rd_data_i = 32'h5A000000 | 32'(fp_rd_index_o);
  fsd_store_decode u_dut (.clk_sys_i, .rst_i, .instr_valid_i, .instr_ready_o, .instr_i,
    .base_value_i, .big_endian_i(be), .fp_rd_index_o, .fp_rd_data_i, .mem_ready_i,
    .mem_fault_i, .mem_valid_o, .mem_addr_o, .mem_data_o, .mem_last_o, .wb_valid_o,
    .wb_index_o, .wb_value_o, .done_o, .fault_o);
  fsd_mem_model u_mem (.clk_sys_i, .rst_i, .mem_valid_i(mem_valid_o), .slow_i(slow),
    .fault_at_i(fault_at), .mem_ready_o(mem_ready_i), .mem_fault_o(mem_fault_i));
  initial
  begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (mem_valid_o === 1'b1 && mem_ready_i === 1'b1)
    begin
      wq.push_back(mem_addr_o);
      dq.push_back(mem_data_o);
    end
    if (cyc == 20000)
    begin
      err_count++;
      results();
    end
  end
  task automatic results();
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] mk(input logic [2:0] puw, input logic d, input logic [3:0] rn,
    input logic [3:0] vd, input logic sz, input logic [7:0] imm);
    return {7'h76, puw[2:1], d, puw[0], 1'b0, rn, vd, 3'h5, sz, imm};
  endfunction
  task automatic run(input logic [31:0] ins, input logic [31:0] base);
    int k;
    k = 0;
    wq.delete();
    dq.delete();
    wbf = 1'b0;
    while (instr_ready_o !== 1'b1 && k < 50)
    begin
      @(negedge clk_sys_i);
      k++;
    end
    @(posedge clk_sys_i);
    instr_i <= ins;
    base_value_i <= base;
    instr_valid_i <= 1'b1;
    @(posedge clk_sys_i);
    instr_valid_i <= 1'b0;
    while (done_o !== 1'b1 && k < 250)
    begin
      @(negedge clk_sys_i);
      k++;
    end
    // Writeback pulses together with done, so it is taken in that same cycle
    wbf = wb_valid_o === 1'b1;
    wbv = wb_value_o;
    wbi = wb_index_o;
    chk(32'(k < 250), 32'h1);
  endtask
  task automatic ver(input int n, input logic [31:0] a0, input logic [3:0] s0, fsd_fault_t f);
    if (n >= 0)
      chk(32'(wq.size()), 32'(n));
    for (int i = 0; i < wq.size(); i++)
    begin
      chk(wq[i], a0 + 32'(4 * i));
      chk(dq[i], 32'h5A000000 | 32'(s0 + 4'(i)));
    end
    chk(32'(fault_o), 32'(f));
  endtask
  task automatic t_single();
    for (int u = 0; u < 2; u++)
    begin
      run(mk({1'b1, 1'(u), 1'b0}, 1'b1, 4'h2, 4'h3, 1'b0, 8'hFF), 32'h00001000);
      ver(1, (u == 1) ? 32'h000013FC : 32'h00000C04, 4'h7, FSD_FLT_NONE);
    end
    run(mk(3'h6, 1'b0, 4'h2, 4'h3, 1'b0, 8'h00), 32'h00001000);
    ver(1, 32'h00001000, 4'h6, FSD_FLT_NONE);
    slow <= 1'b1;
    run(mk(3'h6, 1'b0, 4'h1, 4'h2, 1'b1, 8'h02), 32'h00002000);
    ver(2, 32'h00002008, 4'h4, FSD_FLT_NONE);
    be <= 1'b1;
    run(mk(3'h6, 1'b0, 4'h1, 4'h2, 1'b1, 8'h02), 32'h00002000);
    be <= 1'b0;
    chk(32'(wq.size()), 32'h2);
    chk(wq[1], 32'h0000200C);
    chk(dq[0], 32'h5A000005);
    chk(dq[1], 32'h5A000004);
  endtask
  task automatic t_multi();
    run(mk(3'h3, 1'b0, 4'h5, 4'h1, 1'b0, 8'h03), 32'h00003000);
    ver(3, 32'h00003000, 4'h2, FSD_FLT_NONE);
    chk({wbf, wbi, wbv[26:0]}, {1'b1, 4'h5, 27'h0000300C});
    run(mk(3'h2, 1'b0, 4'h5, 4'h1, 1'b0, 8'h03), 32'h00003000);
    chk(32'(wbf), 32'h0);
    slow <= 1'b0;
    run(mk(3'h5, 1'b0, 4'h5, 4'h1, 1'b1, 8'h04), 32'h00004000);
    ver(4, 32'h00003FF0, 4'h2, FSD_FLT_NONE);
    chk(wbv, 32'h00003FF0);
  endtask
  task automatic t_bad();
    run(mk(3'h1, 1'b0, 4'h2, 4'h0, 1'b0, 8'h02), 32'h00001000);
    ver(0, 32'h0, 4'h0, FSD_FLT_UNDEF);
    run(mk(3'h7, 1'b0, 4'h2, 4'h0, 1'b0, 8'h02), 32'h00001000);
    ver(0, 32'h0, 4'h0, FSD_FLT_UNDEF);
    run(mk(3'h6, 1'b0, 4'hF, 4'h0, 1'b0, 8'h01), 32'h00001000);
    ver(0, 32'h0, 4'h0, FSD_FLT_UNPRED);
    fault_at <= 4'h3;
    run(mk(3'h2, 1'b0, 4'h2, 4'h0, 1'b0, 8'h08), 32'h00005000);
    fault_at <= 4'h0;
    chk(32'(wq.size() < 8), 32'h1);
    ver(-1, 32'h00005000, 4'h0, FSD_FLT_MEM);
  endtask
  initial
  begin
    rst_i = 1'b1;
    instr_valid_i = 1'b0;
    instr_i = '0;
    base_value_i = '0;
    slow = 1'b0;
    be = 1'b0;
    fault_at = 4'h0;
    wbf = 1'b0;
    wbv = '0;
    wbi = 4'h0;
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_single();
    t_multi();
    t_bad();
    results();
  end
endmodule
`default_nettype wire
